// file: logic/urbs_receive_buffer.sv
`timescale 1ns/1ns
`include "urbs_regs.svh"

module urbs_receive_buffer
    import urbs_pkg::*;
#(
    parameter int FIFO_DEPTH = `URBS_FIFO_DEPTH
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       receiver_enable,
    input  wire logic [2:0] character_size_field,
    input  wire logic       parity_enable_bit,
    input  wire logic       parity_odd_select,
    input  wire logic       stop_bit_count_select,
    input  wire logic       receive_complete_irq_enable,
    input  wire logic       global_irq_enable,
    input  wire logic       rx_start,
    input  wire logic       rx_bit_valid,
    input  wire logic       rx_bit,
    input  wire logic       data_read,
    output logic      [7:0] serial_data_register,
    output logic            received_ninth_bit,
    output logic            frame_error_flag,
    output logic            overrun_flag,
    output logic            parity_error_flag,
    output logic            receive_complete_flag,
    output logic            receive_complete_irq,
    output logic            rx_pin_override
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // Pointer wrap relies on a power-of-two depth
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two, at least 2");
    end

    localparam logic [CW-1:0] FULL_COUNT = CW'(FIFO_DEPTH);
    localparam logic [CW-1:0] ONE_COUNT  = CW'(1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        urbs_entry_t [FIFO_DEPTH-1:0] mem;
        logic [PW-1:0]                rd_ptr;
        logic [CW-1:0]                count;
        urbs_rx_state_t               rx_state;
        logic [3:0]                   bit_cnt;
        logic [3:0]                   nbits_cap;
        logic                         par_cap;
        logic                         odd_cap;
        logic [8:0]                   shreg;
        logic                         parity_bit;
        logic                         wait_full;
        urbs_entry_t                  wait_entry;
        logic                         ovr_pending;
    } urbs_state_t;

    urbs_state_t st_reg;
    urbs_state_t st_next;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    // Reserved size codes fall back to eight bits
    function automatic logic [3:0] data_bits(input logic [2:0] csz);
        unique case (csz)
            `URBS_CSZ_5BIT: data_bits = `URBS_BITS_5;
            `URBS_CSZ_6BIT: data_bits = `URBS_BITS_6;
            `URBS_CSZ_7BIT: data_bits = `URBS_BITS_7;
            `URBS_CSZ_9BIT: data_bits = `URBS_BITS_9;
            default:        data_bits = `URBS_BITS_8;
        endcase
    endfunction

    logic [3:0]  last_cnt;
    logic        frame_done;
    logic        fifo_empty;
    urbs_entry_t head;

    // Stop bit slot is the last one; further stop bits are never counted
    assign last_cnt   = st_reg.nbits_cap + {3'h0, st_reg.par_cap};
    assign frame_done = receiver_enable && st_reg.rx_state == URBS_RECV
                        && rx_bit_valid && st_reg.bit_cnt == last_cnt;
    assign fifo_empty = st_reg.count == '0;
    assign head       = st_reg.mem[st_reg.rd_ptr];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        urbs_entry_t   done_entry;
        logic [PW-1:0] wr_idx;
        st_next    = st_reg;
        done_entry = '0;
        wr_idx     = '0;

        // Pop the head on a data read
        if (data_read && !fifo_empty) begin
            st_next.rd_ptr = st_reg.rd_ptr + PW'(1);
            st_next.count  = st_reg.count - ONE_COUNT;
        end

        // Shift in data and parity; the first stop bit only advances the count
        if (st_reg.rx_state == URBS_RECV && rx_bit_valid) begin
            if (st_reg.bit_cnt < st_reg.nbits_cap) begin
                st_next.shreg[st_reg.bit_cnt] = rx_bit;
            end else if (st_reg.par_cap && st_reg.bit_cnt == st_reg.nbits_cap) begin
                st_next.parity_bit = rx_bit;
            end
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end

        if (frame_done) begin
            done_entry.data  = st_reg.shreg[7:0];
            done_entry.ninth = st_reg.shreg[8];
            done_entry.fe    = !rx_bit;
            done_entry.upe   = st_reg.par_cap
                               && (^st_reg.shreg ^ st_reg.parity_bit ^ st_reg.odd_cap);
            st_next.wait_entry = done_entry;
            st_next.wait_full  = 1'b1;
            st_next.rx_state   = URBS_IDLE;
        end

        // Move a waiting character in as soon as there is room
        if (st_next.wait_full && st_next.count < FULL_COUNT) begin
            wr_idx = PW'(st_next.rd_ptr + PW'(st_next.count));
            st_next.mem[wr_idx]     = st_next.wait_entry;
            st_next.mem[wr_idx].dor = st_reg.ovr_pending;
            st_next.count           = st_next.count + ONE_COUNT;
            st_next.wait_full       = 1'b0;
            st_next.ovr_pending     = 1'b0;
        end

        // A start bit while still full drops the waiting character
        if (rx_start && st_reg.rx_state == URBS_IDLE) begin
            if (st_next.wait_full) begin
                st_next.ovr_pending = 1'b1;
                st_next.wait_full   = 1'b0;
            end
            st_next.rx_state  = URBS_RECV;
            st_next.bit_cnt   = 4'h0;
            st_next.shreg     = `URBS_SHREG_RST;
            st_next.nbits_cap = data_bits(character_size_field);
            st_next.par_cap   = parity_enable_bit;
            st_next.odd_cap   = parity_odd_select;
        end

        // Disable wins over everything: flush and abandon at once
        if (!receiver_enable) begin
            st_next.count       = '0;
            st_next.rx_state    = URBS_IDLE;
            st_next.wait_full   = 1'b0;
            st_next.ovr_pending = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Flags are taken from the FIFO only, so no write path can reach them
    assign serial_data_register  = fifo_empty ? `URBS_BYTE_ZERO : head.data;
    assign received_ninth_bit    = !fifo_empty && head.ninth;
    assign frame_error_flag      = !fifo_empty && head.fe;
    assign overrun_flag          = !fifo_empty && head.dor;
    assign parity_error_flag     = !fifo_empty && head.upe;
    assign receive_complete_flag = !fifo_empty;
    // Error flags have no path into the request
    assign receive_complete_irq  = receive_complete_flag
                                   && receive_complete_irq_enable && global_irq_enable;
    assign rx_pin_override       = receiver_enable;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence seq_disable;
        receiver_enable ##1 !receiver_enable;
    endsequence

    sequence seq_stop_seen;
        frame_done;
    endsequence

    // Last entry leaves and no frame lands in the same cycle
    sequence seq_last_pop;
        receiver_enable && data_read && st_reg.count == ONE_COUNT && !frame_done;
    endsequence

    sequence seq_overrun_start;
        receiver_enable && rx_start && st_reg.rx_state == URBS_IDLE && st_reg.wait_full
        && st_reg.count == FULL_COUNT && !data_read;
    endsequence

    // A character only waits while the FIFO is full, so only a pop frees room
    sequence seq_room_freed;
        receiver_enable && st_reg.wait_full && data_read && !fifo_empty;
    endsequence

    // ----------------------------------------------------------------
    // Receiver enable
    // ----------------------------------------------------------------
    chk_disable_flush: assert property (seq_disable |=> !receive_complete_flag
        && st_reg.rx_state == URBS_IDLE)
        else $error("Receiver disable did not flush");

    chk_abandon_frame: assert property (!receiver_enable |=> !st_reg.wait_full
        && st_reg.rx_state == URBS_IDLE)
        else $error("Frame survived receiver disable");

    chk_pin_release: assert property (rx_pin_override == receiver_enable)
        else $error("Receive pin ownership does not follow enable");

    // ----------------------------------------------------------------
    // FIFO, flags and interrupt
    // ----------------------------------------------------------------
    chk_irq_source: assert property (receive_complete_irq |-> !fifo_empty
        && receive_complete_irq_enable)
        else $error("Interrupt without unread data");

    chk_irq_follow: assert property (receive_complete_flag
        && receive_complete_irq_enable && global_irq_enable |-> receive_complete_irq)
        else $error("Interrupt missing while data waits");

    chk_err_no_irq: assert property ((frame_error_flag || overrun_flag
        || parity_error_flag) && !receive_complete_irq_enable |-> !receive_complete_irq)
        else $error("Error flag raised an interrupt");

    chk_empty_clear: assert property (fifo_empty |-> !receive_complete_flag
        && serial_data_register == `URBS_BYTE_ZERO && !received_ninth_bit
        && !frame_error_flag && !overrun_flag && !parity_error_flag)
        else $error("Empty FIFO shows data or flags");

    chk_last_pop: assert property (seq_last_pop |=> !receive_complete_flag)
        else $error("Flag stayed set after the last read");

    chk_pop_advance: assert property (receiver_enable && data_read && !fifo_empty
        |=> st_reg.rd_ptr != $past(st_reg.rd_ptr))
        else $error("Data read did not advance the FIFO");

    // ----------------------------------------------------------------
    // Frame assembly
    // ----------------------------------------------------------------
    chk_stop_fe: assert property (seq_stop_seen |=>
        st_reg.wait_entry.fe == !$past(rx_bit))
        else $error("Frame error does not match stop bit");

    chk_one_stop: assert property (seq_stop_seen ##0 stop_bit_count_select
        |=> st_reg.wait_entry.fe == !$past(rx_bit) && st_reg.rx_state == URBS_IDLE)
        else $error("Second stop bit changed the frame result");

    chk_parity_off: assert property (seq_stop_seen ##0 !st_reg.par_cap
        |=> !st_reg.wait_entry.upe)
        else $error("Parity error with checking off");

    chk_short_zero: assert property (seq_stop_seen
        ##0 st_reg.nbits_cap < `URBS_BITS_8
        |=> (st_reg.wait_entry.data >> $past(st_reg.nbits_cap)) == `URBS_BYTE_ZERO)
        else $error("Unused data bits not zero");

    chk_transfer_empty: assert property (seq_stop_seen ##0 fifo_empty
        |=> receive_complete_flag ##0 st_reg.count == ONE_COUNT)
        else $error("Completed frame not moved into FIFO");

    // ----------------------------------------------------------------
    // Overrun
    // ----------------------------------------------------------------
    chk_overrun_keep: assert property (seq_overrun_start
        |=> st_reg.ovr_pending && $stable(st_reg.mem) && !st_reg.wait_full)
        else $error("Overrun altered FIFO or missed flag");

    chk_overrun_clear: assert property (seq_room_freed
        |=> !st_reg.ovr_pending && !st_reg.wait_full)
        else $error("Overrun not cleared on transfer");

    chk_overrun_tag: assert property (seq_room_freed ##0 st_reg.ovr_pending
        |=> st_reg.mem[$past(st_reg.rd_ptr)].dor)
        else $error("Overrun not marked on the next entry");

endmodule

// file: logic/urbs_regs.svh
`ifndef URBS_REGS_SVH
`define URBS_REGS_SVH

// ----------------------------------------------------------------
// Receive buffer sizing
// ----------------------------------------------------------------
`define URBS_FIFO_DEPTH     2

// ----------------------------------------------------------------
// Character size field encodings
// ----------------------------------------------------------------
`define URBS_CSZ_5BIT       3'h0
`define URBS_CSZ_6BIT       3'h1
`define URBS_CSZ_7BIT       3'h2
`define URBS_CSZ_8BIT       3'h3
`define URBS_CSZ_9BIT       3'h7

// ----------------------------------------------------------------
// Data bit counts and reset values
// ----------------------------------------------------------------
`define URBS_BITS_5         4'h5
`define URBS_BITS_6         4'h6
`define URBS_BITS_7         4'h7
`define URBS_BITS_8         4'h8
`define URBS_BITS_9         4'h9
`define URBS_SHREG_RST      9'h000
`define URBS_BYTE_ZERO      8'h00

`endif

// file: logic/urbs_pkg.sv
package urbs_pkg;

    typedef enum logic {
        URBS_IDLE,
        URBS_RECV
    } urbs_rx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       fe;
        logic       dor;
        logic       upe;
    } urbs_entry_t;

endpackage

// file: tb/urbs_tx_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Remote transmitter, as seen after bit voting
// ----------------------------------------------------------------
module urbs_tx_model (
    input  wire logic mclk,
    output logic      rx_start,
    output logic      rx_bit_valid,
    output logic      rx_bit
);
    int gap = 0;

    initial begin
        rx_start     = 1'b0;
        rx_bit_valid = 1'b0;
        rx_bit       = 1'b1;
    end

    // Idle cycles flip the bit line so stale data never looks valid
    task automatic put_bit(input logic b);
        rx_bit       = b;
        rx_bit_valid = 1'b1;
        @(negedge mclk);
        if (gap > 0) begin
            rx_bit_valid = 1'b0;
            rx_bit       = ~b;
            repeat (gap) @(negedge mclk);
        end
    endtask

    // Start, data LSB first, optional parity, one stop bit
    task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic pb,
                        input logic stop);
        @(negedge mclk);
        rx_start = 1'b1;
        @(negedge mclk);
        rx_start = 1'b0;
        for (int i = 0; i < nb; i++) begin
            put_bit(d[i]);
        end
        if (pe) begin
            put_bit(pb);
        end
        put_bit(stop);
        rx_bit_valid = 1'b0;
        rx_bit       = ~stop;
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "urbs_regs.svh"

module tb_top;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic       receiver_enable = 1'b1;
    logic [2:0] character_size_field = `URBS_CSZ_8BIT;
    logic       parity_enable_bit = 1'b0;
    logic       parity_odd_select = 1'b0;
    logic       stop_bit_count_select = 1'b0;
    logic       receive_complete_irq_enable = 1'b1;
    logic       global_irq_enable = 1'b1;
    logic       data_read = 1'b0;
    logic       rx_start, rx_bit_valid, rx_bit;
    logic [7:0] serial_data_register;
    logic       received_ninth_bit, frame_error_flag, overrun_flag, parity_error_flag;
    logic       receive_complete_flag, receive_complete_irq, rx_pin_override;
    int         error_cnt = 0;
    int         num_checks = 0;

    always #2 mclk = ~mclk;

    urbs_tx_model tx (.mclk, .rx_start, .rx_bit_valid, .rx_bit);

    urbs_receive_buffer #(.FIFO_DEPTH(2)) DUT (
        .mclk, .reset_n, .receiver_enable, .character_size_field, .parity_enable_bit,
        .parity_odd_select, .stop_bit_count_select, .receive_complete_irq_enable,
        .global_irq_enable, .rx_start, .rx_bit_valid, .rx_bit, .data_read,
        .serial_data_register, .received_ninth_bit, .frame_error_flag, .overrun_flag,
        .parity_error_flag, .receive_complete_flag, .receive_complete_irq, .rx_pin_override);

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Status is read first, data afterwards; status is never written back
    task automatic head(input logic [7:0] d, input logic [3:0] st);
        chk("flag", 9'h1, {8'h00, receive_complete_flag});
        chk("status", {5'h00, st}, {5'h00, received_ninth_bit, frame_error_flag,
            overrun_flag, parity_error_flag});
        chk("data", {1'b0, d}, {1'b0, serial_data_register});
    endtask

    task automatic pop();
        @(negedge mclk);
        data_read = 1'b1;
        @(negedge mclk);
        data_read = 1'b0;
    endtask

    task automatic frame(input logic [8:0] d, input int nb, input logic pb, input logic stop);
        tx.send(d, nb, parity_enable_bit, pb, stop);
        @(negedge mclk);
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_basic();
        frame(9'h0a5, 8, 1'b0, 1'b1);
        head(8'ha5, 4'h0);
        chk("irq", 9'h1, {8'h00, receive_complete_irq});
        global_irq_enable = 1'b0;
        @(negedge mclk);
        chk("irq_gated", 9'h0, {8'h00, receive_complete_irq});
        global_irq_enable = 1'b1;
        pop();
        chk("irq_cleared", 9'h0, {8'h00, receive_complete_irq});
        chk("empty_data", 9'h0, {1'b0, serial_data_register});
    endtask

    task automatic t_ninth_fe();
        character_size_field = `URBS_CSZ_9BIT;
        stop_bit_count_select = 1'b1;
        receive_complete_irq_enable = 1'b0;
        frame(9'h1c3, 9, 1'b0, 1'b0);
        head(8'hc3, 4'hc);
        chk("irq_err", 9'h0, {8'h00, receive_complete_irq});
        pop();
        character_size_field = `URBS_CSZ_8BIT;
        stop_bit_count_select = 1'b0;
        receive_complete_irq_enable = 1'b1;
    endtask

    task automatic t_parity();
        logic [7:0] d;
        parity_enable_bit = 1'b1;
        for (int k = 0; k < 4; k++) begin
            d = 8'h5a + 8'(k);
            parity_odd_select = k[1];
            frame({1'b0, d}, 8, (^d) ^ k[1] ^ k[0], 1'b1);
            head(d, {3'b000, k[0]});
            pop();
        end
        parity_enable_bit = 1'b0;
        frame(9'h0e0, 8, 1'b0, 1'b1);
        head(8'he0, 4'h0);
        pop();
    endtask

    task automatic t_sizes();
        tx.gap = 2;
        for (int s = 0; s < 4; s++) begin
            character_size_field = 3'(s);
            frame(9'h1ff, 5 + s, 1'b0, 1'b1);
            head(8'hff >> (3 - s), 4'h0);
            pop();
        end
        tx.gap = 0;
    endtask

    task automatic t_overrun();
        frame(9'h011, 8, 1'b0, 1'b1);
        frame(9'h022, 8, 1'b0, 1'b0);
        frame(9'h033, 8, 1'b0, 1'b1);
        frame(9'h044, 8, 1'b0, 1'b1);
        head(8'h11, 4'h0);
        pop();
        head(8'h22, 4'h4);
        pop();
        head(8'h44, 4'h2);
        pop();
        chk("drained", 9'h0, {8'h00, receive_complete_flag});
        frame(9'h055, 8, 1'b0, 1'b1);
        head(8'h55, 4'h0);
        pop();
    endtask

    task automatic t_disable();
        chk("pin_taken", 9'h1, {8'h00, rx_pin_override});
        frame(9'h066, 8, 1'b0, 1'b1);
        frame(9'h077, 8, 1'b0, 1'b1);
        fork
            tx.send(9'h088, 8, 1'b0, 1'b0, 1'b1);
            begin
                repeat (4) @(negedge mclk);
                receiver_enable = 1'b0;
            end
        join
        @(negedge mclk);
        chk("flushed", 9'h0, {8'h00, receive_complete_flag});
        chk("pin_free", 9'h0, {8'h00, rx_pin_override});
        receiver_enable = 1'b1;
        frame(9'h099, 8, 1'b0, 1'b1);
        head(8'h99, 4'h0);
        pop();
    endtask

    task automatic t_flush();
        int n;
        n = 0;
        frame(9'h0aa, 8, 1'b0, 1'b1);
        frame(9'h0bb, 8, 1'b0, 1'b1);
        while (receive_complete_flag === 1'b1 && n < 4) begin
            pop();
            n++;
        end
        chk("flush_reads", 9'h2, 9'(n));
    endtask

    initial begin
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        t_basic();
        t_ninth_fe();
        t_parity();
        t_sizes();
        t_overrun();
        t_disable();
        t_flush();
        complete_run();
    end

    // A hang is cut well past the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end
endmodule
